// ### pdmc_clkdiv.sv
// Microphone clock divider: level plus one-cycle rise and fall enables
// Assumes div is held stable while run is high
`timescale 1ns/1ns
`include "pdmc_defs.svh"
module pdmc_clkdiv import pdmc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [5:0] div,
    output logic lvl,
    output logic rise_en,
    output logic fall_en
);
    logic [5:0] cnt_r; // Position within one mic clock period
    logic [5:0] half; // Where the falling edge sits
    logic [5:0] gap_r; // Helper: cycles since last rise
    logic seen_r; // Helper: one rise already seen

    assign half = {1'b0, div[5:1]};
    assign rise_en = run && (cnt_r == 6'h00);
    assign fall_en = run && (cnt_r == half);
    assign lvl = run && (cnt_r < half);

    // Period counter, held at zero when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 6'h00;
        end else if (!run || cnt_r == div - 6'h01) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    // Helper for the period check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= 6'h00;
            seen_r <= 1'b0;
        end else if (!run) begin
            seen_r <= 1'b0;
        end else if (rise_en) begin
            gap_r <= 6'h01;
            seen_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 6'h01;
        end
    end

    property p_div_period;
        @(posedge clk) disable iff (!rst_n)
        rise_en && seen_r && $stable(div) |-> gap_r == div;
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("mic clock period differs from divisor");
endmodule // pdmc_clkdiv

// ### pdmc_core.sv
// PDM microphone capture: config registers, capture, gain, packing, DMA
// Assumes a DMA port that always accepts and a clocked register master
// What this block does
// - Stereo word packs right high, left low
// - Mono word packs earlier low, later high
// - Edge field picks left capture edge
// - Left gain in half dB steps
// - Both gains reset to unity code
// - Right gain uses the same coding
// - DMA writes start at buffer pointer
// - Buffer length bounds samples per buffer
// - Mic clock routed to selected pin
// - Mic data taken from selected pin
// - End event after last sample written
// - Default divider divides reference by 31
`timescale 1ns/1ns
`include "pdmc_defs.svh"
module pdmc_core import pdmc_pkg::*; #(
    parameter int PIN_W = 5,
    parameter int CNT_W = 15
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    input wire logic [2**PIN_W-1:0] PIN_IN,
    output logic [2**PIN_W-1:0] PIN_OUT,
    output logic [2**PIN_W-1:0] PIN_OE,
    output logic [31:0] DMA_ADDR,
    output logic [31:0] DMA_WDATA,
    output logic DMA_WE
);
    localparam int NPINS = 2**PIN_W;

    // Map divider setting to a divisor; unknown codes fall back to default
    function automatic logic [5:0] div_of(input logic [31:0] cfg);
        case (cfg)
            `PDMC_DIV_1000K: return 6'd32;
            `PDMC_DIV_1067K: return 6'd30;
            `PDMC_DIV_1231K: return 6'd26;
            `PDMC_DIV_1280K: return 6'd25;
            `PDMC_DIV_1333K: return 6'd24;
            default: return 6'd31;
        endcase
    endfunction

    // Ones count over one decimation window to signed PCM
    function automatic logic [15:0] to_pcm(input logic [6:0] ones, input logic [6:0] n);
        int v;
        v = (int'(ones) * 2 - int'(n)) * 256;
        return 16'(v);
    endfunction

    // Gain of 2^(d/12) per 6 dB octave with a Q8 fractional table, saturating
    function automatic logic [15:0] apply_gain(input logic [15:0] s, input logic [6:0] code);
        int d;
        int oct;
        int m;
        longint p;
        d = int'(code) - int'(`PDMC_GAIN_UNITY) + 4 * `PDMC_GAIN_STEPS_6DB;
        oct = d / `PDMC_GAIN_STEPS_6DB - 4;
        case (d % `PDMC_GAIN_STEPS_6DB)
            0: m = 256;
            1: m = 271;
            2: m = 287;
            3: m = 304;
            4: m = 323;
            5: m = 342;
            6: m = 362;
            7: m = 384;
            8: m = 406;
            9: m = 431;
            10: m = 456;
            default: m = 483;
        endcase
        p = longint'($signed(s)) * longint'(m);
        p = (oct >= 0) ? (p <<< oct) : (p >>> (-oct));
        p = p >>> 8;
        if (p > 32767) p = 32767; // Clip rather than wrap
        if (p < -32768) p = -32768;
        return 16'(p);
    endfunction

    // Clamp a written gain code to the allowed range
    function automatic logic [6:0] clamp_gain(input logic [6:0] c);
        return (c > `PDMC_GAIN_HIGH) ? `PDMC_GAIN_HIGH : c;
    endfunction

    // Software-visible registers
    logic en_r; // Block enable
    logic [31:0] clkdiv_r; // Mic clock divider setting
    logic mono_r; // Channel layout: 1 mono
    logic edge_r; // Left edge: 1 rising
    logic [6:0] gain_l_r; // Left gain code
    logic [6:0] gain_r_r; // Right gain code
    pdmc_ratio_t ratio_r; // Decimation ratio
    logic [31:0] psel_clk_r; // Clock pin select
    logic [31:0] psel_din_r; // Data pin select
    logic [31:0] ptr_r; // Buffer pointer as written
    logic [CNT_W-1:0] maxcnt_r; // Buffer length in samples
    logic [2:0] status_r; // Sticky events
    logic [2:0] mask_r; // Interrupt mask
    logic [31:0] rdata_r; // Read data, one cycle late
    logic irq_r; // Interrupt level

    // Capture and packing state
    pdmc_state_t state_r;
    logic [NPINS-1:0] sy1_r, sy2_r, sy3_r, din_r; // Data pin synchroniser
    logic [6:0] ones_l_r, ones_rt_r, bits_r; // Decimation accumulators
    logic [15:0] raw_l_r, raw_rt_r, g_l_r, g_rt_r, l0_r; // Sample pipeline
    logic stb1_r, stb2_r, half_r; // Pipeline strobes, mono half filled
    logic [31:0] ptr_act_r; // Pointer latched for current buffer
    logic [CNT_W-1:0] word_idx_r; // Word index in current buffer
    logic [CNT_W:0] smp_cnt_r; // Samples written to current buffer
    logic [31:0] dma_addr_r, dma_wdata_r;
    logic dma_we_r;
    logic [NPINS-1:0] pin_out_r, pin_oe_r;
    logic gain_wr_seen_r; // Helper: a gain write has happened
    logic first_pend_r; // Helper: no word written since start

    // Register decode
    wire wr_task = WR && ADDR == `PDMC_OFS_TASK;
    wire rd_stat = RD && ADDR == `PDMC_OFS_STATUS;
    wire start_req = wr_task && WDATA[`PDMC_TASK_START] && en_r;
    wire stop_req = wr_task && WDATA[`PDMC_TASK_STOP];
    wire running = state_r == PDMC_ST_RUN;
    wire [6:0] ratio_n = (ratio_r == PDMC_DEC_X80) ? `PDMC_DEC_X80 : `PDMC_DEC_X64;

    // Mic clock generation
    logic clk_lvl, rise_en, fall_en;
    pdmc_clkdiv u_div (
        .clk(MCLK),
        .rst_n(RESET_N),
        .run(running),
        .div(div_of(clkdiv_r)),
        .lvl(clk_lvl),
        .rise_en(rise_en),
        .fall_en(fall_en)
    );

    // Capture strobes: left on the chosen edge, right on the other
    wire cap_l = edge_r ? rise_en : fall_en;
    wire cap_rt = !mono_r && (edge_r ? fall_en : rise_en);
    wire din_bit = !psel_din_r[`PDMC_PSEL_DISC] && din_r[psel_din_r[PIN_W-1:0]];
    wire dec_done = cap_l && bits_r == ratio_n - 7'h01;
    wire [NPINS-1:0] clk_onehot = psel_clk_r[`PDMC_PSEL_DISC] ? '0 :
        (NPINS'(1) << psel_clk_r[PIN_W-1:0]);

    // A word leaves on a stereo sample or on the second mono sample
    wire wr_word = stb2_r && running && (!mono_r || half_r);
    wire [31:0] word = mono_r ? {g_l_r, l0_r} : {g_rt_r, g_l_r};
    wire [CNT_W:0] smp_nxt = smp_cnt_r + (CNT_W+1)'(2);
    wire buf_full = wr_word && smp_nxt >= {1'b0, maxcnt_r};

    // Events: started, stopped, end
    wire ev_start = start_req && !running;
    wire ev_stop = stop_req && running;
    wire [2:0] ev_set = {buf_full || ev_stop, ev_stop, ev_start};
    wire [2:0] status_nxt = (status_r & (rd_stat ? 3'h0 : 3'h7)) | ev_set;

    // Read data selection
    wire [31:0] rd_mux =
        (ADDR == `PDMC_OFS_STATUS) ? {29'h0, status_r} :
        (ADDR == `PDMC_OFS_IRQMASK) ? {29'h0, mask_r} :
        (ADDR == `PDMC_OFS_ENABLE) ? {31'h0, en_r} :
        (ADDR == `PDMC_OFS_CLKDIV) ? clkdiv_r :
        (ADDR == `PDMC_OFS_ROUTING) ? {30'h0, edge_r, mono_r} :
        (ADDR == `PDMC_OFS_GAIN_LEFT) ? {25'h0, gain_l_r} :
        (ADDR == `PDMC_OFS_GAIN_RIGHT) ? {25'h0, gain_r_r} :
        (ADDR == `PDMC_OFS_RATIO) ? {31'h0, ratio_r == PDMC_DEC_X80} :
        (ADDR == `PDMC_OFS_PSELCLK) ? psel_clk_r :
        (ADDR == `PDMC_OFS_PSELDIN) ? psel_din_r :
        (ADDR == `PDMC_OFS_PTR) ? ptr_r :
        (ADDR == `PDMC_OFS_MAXCNT) ? {{(32-CNT_W){1'b0}}, maxcnt_r} :
        32'h0; // Unmapped reads as zero

    // Configuration writes; divider reprogramming is left to software
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            en_r <= 1'b0;
            clkdiv_r <= `PDMC_RST_CLKDIV;
            {edge_r, mono_r} <= 2'h0;
            gain_l_r <= `PDMC_GAIN_UNITY;
            gain_r_r <= `PDMC_GAIN_UNITY;
            ratio_r <= PDMC_DEC_X64;
            psel_clk_r <= `PDMC_RST_PSEL;
            psel_din_r <= `PDMC_RST_PSEL;
            ptr_r <= 32'h0;
            maxcnt_r <= '0;
            mask_r <= 3'h0;
        end else if (WR) begin
            case (ADDR)
                `PDMC_OFS_ENABLE: en_r <= WDATA[0];
                `PDMC_OFS_IRQMASK: mask_r <= WDATA[2:0];
                `PDMC_OFS_CLKDIV: clkdiv_r <= WDATA;
                `PDMC_OFS_ROUTING: {edge_r, mono_r} <= WDATA[1:0];
                `PDMC_OFS_GAIN_LEFT: gain_l_r <= clamp_gain(WDATA[6:0]);
                `PDMC_OFS_GAIN_RIGHT: gain_r_r <= clamp_gain(WDATA[6:0]);
                `PDMC_OFS_RATIO: ratio_r <= pdmc_ratio_t'(WDATA[0]);
                `PDMC_OFS_PSELCLK: psel_clk_r <= WDATA;
                `PDMC_OFS_PSELDIN: psel_din_r <= WDATA;
                `PDMC_OFS_PTR: ptr_r <= WDATA;
                `PDMC_OFS_MAXCNT: maxcnt_r <= WDATA[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Read port, status and interrupt; a new event beats a read clear
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 32'h0;
            status_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= RD ? rd_mux : 32'h0;
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask_r);
        end
    end

    // Run state; disabling the block also halts it
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= PDMC_ST_IDLE;
        end else if (ev_start) begin
            state_r <= PDMC_ST_RUN;
        end else if (stop_req || !en_r) begin
            state_r <= PDMC_ST_IDLE;
        end
    end

    // Three-stage pin synchroniser; a change counts when stages two and three agree
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {sy1_r, sy2_r, sy3_r, din_r} <= '0;
        end else begin
            sy1_r <= PIN_IN;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            din_r <= (sy2_r & sy3_r) | (din_r & (sy2_r | sy3_r));
        end
    end

    // Decimation: count ones per window of ratio_n left captures
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {ones_l_r, ones_rt_r, bits_r} <= '0;
        end else if (!running) begin
            {ones_l_r, ones_rt_r, bits_r} <= '0;
        end else begin
            if (cap_l) begin
                bits_r <= dec_done ? 7'h00 : bits_r + 7'h01;
                ones_l_r <= dec_done ? 7'h00 : ones_l_r + {6'h0, din_bit};
            end
            if (dec_done) begin
                ones_rt_r <= {6'h0, cap_rt && din_bit}; // Right window restarts with left
            end else if (cap_rt) begin
                ones_rt_r <= ones_rt_r + {6'h0, din_bit};
            end
        end
    end

    // Sample pipeline: raw PCM, then gain
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {raw_l_r, raw_rt_r, g_l_r, g_rt_r} <= '0;
            {stb1_r, stb2_r} <= 2'h0;
        end else begin
            stb1_r <= dec_done && running;
            stb2_r <= stb1_r;
            if (dec_done) begin
                raw_l_r <= to_pcm(ones_l_r + {6'h0, din_bit}, ratio_n);
                raw_rt_r <= to_pcm(ones_rt_r, ratio_n);
            end
            if (stb1_r) begin
                g_l_r <= apply_gain(raw_l_r, gain_l_r);
                g_rt_r <= apply_gain(raw_rt_r, gain_r_r);
            end
        end
    end

    // Packing and DMA; a full buffer restarts at the current pointer
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {half_r, dma_we_r} <= 2'h0;
            {l0_r, dma_addr_r, dma_wdata_r, ptr_act_r} <= '0;
            word_idx_r <= '0;
            smp_cnt_r <= '0;
        end else begin
            dma_we_r <= wr_word;
            if (ev_start) begin
                ptr_act_r <= ptr_r;
                word_idx_r <= '0;
                smp_cnt_r <= '0;
                half_r <= 1'b0;
            end else if (stb2_r && running && mono_r && !half_r) begin
                l0_r <= g_l_r;
                half_r <= 1'b1;
            end else if (wr_word) begin
                dma_addr_r <= ptr_act_r + {{(30-CNT_W){1'b0}}, word_idx_r, 2'b00};
                dma_wdata_r <= word;
                half_r <= 1'b0;
                word_idx_r <= buf_full ? '0 : word_idx_r + CNT_W'(1);
                smp_cnt_r <= buf_full ? '0 : smp_nxt;
                if (buf_full) begin
                    ptr_act_r <= ptr_r; // Next buffer takes a freshly written pointer
                end
            end
        end
    end

    // Pin drivers; the selected clock pin is driven low while idle
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else begin
            pin_out_r <= clk_lvl ? clk_onehot : '0;
            pin_oe_r <= clk_onehot;
        end
    end

    // Helper for the gain reset check
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gain_wr_seen_r <= 1'b0;
        end else if (WR && (ADDR == `PDMC_OFS_GAIN_LEFT || ADDR == `PDMC_OFS_GAIN_RIGHT)) begin
            gain_wr_seen_r <= 1'b1;
        end
    end

    // Helper for the first-address check; a counter-free flag instead of a long repetition
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            first_pend_r <= 1'b0;
        end else if (ev_start) begin
            first_pend_r <= 1'b1;
        end else if (wr_word) begin
            first_pend_r <= 1'b0;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ = irq_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE = pin_oe_r;
    assign DMA_ADDR = dma_addr_r;
    assign DMA_WDATA = dma_wdata_r;
    assign DMA_WE = dma_we_r;

    property p_stereo_pack;
        @(posedge MCLK) disable iff (!RESET_N)
        wr_word && !mono_r |=> DMA_WE && DMA_WDATA == {$past(g_rt_r), $past(g_l_r)};
    endproperty
    a_stereo_pack: assert property (p_stereo_pack)
        else $error("stereo word not right-high left-low");

    property p_mono_pack;
        @(posedge MCLK) disable iff (!RESET_N)
        wr_word && mono_r
        |=> DMA_WE && DMA_WDATA[15:0] == $past(l0_r) && DMA_WDATA[31:16] == $past(g_l_r);
    endproperty
    a_mono_pack: assert property (p_mono_pack)
        else $error("mono word not earlier-low later-high");

    property p_left_edge;
        @(posedge MCLK) disable iff (!RESET_N)
        cap_l && running |-> (edge_r ? $rose(clk_lvl) : $fell(clk_lvl));
    endproperty
    a_left_edge: assert property (p_left_edge)
        else $error("left captured on wrong edge");

    property p_right_edge;
        @(posedge MCLK) disable iff (!RESET_N)
        cap_rt |-> !mono_r && !cap_l && (edge_r ? fall_en : rise_en);
    endproperty
    a_right_edge: assert property (p_right_edge)
        else $error("right not captured on opposite edge");

    property p_half_gain;
        @(posedge MCLK) disable iff (!RESET_N)
        stb1_r && gain_l_r == 7'h1C |=> g_l_r == {$past(raw_l_r[15]), $past(raw_l_r[15:1])};
    endproperty
    a_half_gain: assert property (p_half_gain)
        else $error("left gain of minus 6 dB did not halve the sample");

    property p_gain_reset;
        @(posedge MCLK) disable iff (!RESET_N)
        !gain_wr_seen_r |-> gain_l_r == 7'h28 && gain_r_r == 7'h28;
    endproperty
    a_gain_reset: assert property (p_gain_reset)
        else $error("gain code not at reset value");

    property p_right_gain_range;
        @(posedge MCLK) disable iff (!RESET_N)
        WR && ADDR == `PDMC_OFS_GAIN_RIGHT |=> gain_r_r ==
            (($past(WDATA[6:0]) > 7'h50) ? 7'h50 : $past(WDATA[6:0]));
    endproperty
    a_right_gain_range: assert property (p_right_gain_range)
        else $error("right gain code not stored as written or clamped");

    property p_first_addr;
        @(posedge MCLK) disable iff (!RESET_N)
        wr_word && first_pend_r
        |=> DMA_WE && DMA_ADDR == $past(ptr_act_r) && $past(ptr_act_r) == $past(ptr_r, 1);
    endproperty
    a_first_addr: assert property (p_first_addr)
        else $error("first DMA word not at buffer pointer");

    property p_end_event;
        @(posedge MCLK) disable iff (!RESET_N)
        buf_full |=> DMA_WE ##0 status_r[`PDMC_EV_END] ##0 smp_cnt_r == '0;
    endproperty
    a_end_event: assert property (p_end_event)
        else $error("end event missing after last sample");

    property p_clk_route;
        @(posedge MCLK) disable iff (!RESET_N)
        !psel_clk_r[`PDMC_PSEL_DISC] |=> PIN_OE[$past(psel_clk_r[PIN_W-1:0])]
            && PIN_OUT[$past(psel_clk_r[PIN_W-1:0])] == $past(clk_lvl);
    endproperty
    a_clk_route: assert property (p_clk_route)
        else $error("mic clock not on selected pin");
endmodule // pdmc_core

// ### pdmc_defs.svh
// Register offsets, field positions, reset values and divider codes
// Assumes a 12-bit byte address from the plain register port
`ifndef PDMC_DEFS_SVH
`define PDMC_DEFS_SVH
`define PDMC_OFS_TASK 12'h000
`define PDMC_OFS_STATUS 12'h100
`define PDMC_OFS_IRQMASK 12'h300
`define PDMC_OFS_ENABLE 12'h500
`define PDMC_OFS_CLKDIV 12'h504
`define PDMC_OFS_ROUTING 12'h508
`define PDMC_OFS_GAIN_LEFT 12'h518
`define PDMC_OFS_GAIN_RIGHT 12'h51C
`define PDMC_OFS_RATIO 12'h520
`define PDMC_OFS_PSELCLK 12'h540
`define PDMC_OFS_PSELDIN 12'h544
`define PDMC_OFS_PTR 12'h560
`define PDMC_OFS_MAXCNT 12'h564
`define PDMC_TASK_START 0
`define PDMC_TASK_STOP 1
`define PDMC_EV_STARTED 0
`define PDMC_EV_STOPPED 1
`define PDMC_EV_END 2
`define PDMC_ROUTE_MONO 0
`define PDMC_ROUTE_EDGE 1
`define PDMC_PSEL_DISC 31
`define PDMC_RST_CLKDIV 32'h08400000
`define PDMC_RST_PSEL 32'h80000000
`define PDMC_GAIN_LOW 7'h00
`define PDMC_GAIN_UNITY 7'h28
`define PDMC_GAIN_HIGH 7'h50
`define PDMC_GAIN_STEPS_6DB 12
`define PDMC_DEC_X64 7'h40
`define PDMC_DEC_X80 7'h50
`define PDMC_DIV_1000K 32'h08000000
`define PDMC_DIV_1067K 32'h08800000
`define PDMC_DIV_1231K 32'h09800000
`define PDMC_DIV_1280K 32'h0A000000
`define PDMC_DIV_1333K 32'h0A800000
`endif

// ### pdmc_mic_model.sv
// Model of a left and a right PDM microphone sharing one data line
// Assumes the bench hands over the clock and data pin numbers it programmed
`timescale 1ns/1ns
module pdmc_mic_model (
    input wire logic clk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [4:0] clk_pin,
    input wire logic [4:0] din_pin,
    output logic [31:0] pin_in
);
    logic [31:0] noise_r = 32'h1357_9BDF; // Pattern on every other pin
    logic mic_clk; // Clock as seen on the selected pin
    logic mic_dat; // Shared data line
    assign mic_clk = pin_oe[clk_pin] & pin_out[clk_pin];
    // Left mic sends all ones while clock high, right all zeros while low
    assign mic_dat = mic_clk;
    // Changes every cycle, so a wrong data pin never reads a steady level
    always_ff @(posedge clk) begin
        noise_r <= noise_r + 32'h9E37_79B9;
    end
    // Data lands only on the selected pin
    always_comb begin
        pin_in = noise_r;
        pin_in[din_pin] = mic_dat;
    end
endmodule // pdmc_mic_model

// ### pdmc_pkg.sv
// Types shared by the capture block and its clock divider
// Assumes nothing beyond the constants header
package pdmc_pkg;
    typedef enum logic {PDMC_ST_IDLE = 1'b0, PDMC_ST_RUN = 1'b1} pdmc_state_t;
    typedef enum logic {PDMC_DEC_X64 = 1'b0, PDMC_DEC_X80 = 1'b1} pdmc_ratio_t;
endpackage

// ### tb.sv
// Self-checking bench for the capture block with a two-microphone model
// Assumes the register map and word packing of the capture block
`timescale 1ns/1ns
`include "pdmc_defs.svh"
module tb;
    logic MCLK, RESET_N, WR, RD;
    logic [11:0] ADDR;
    logic [31:0] WDATA, r, ptr;
    logic [31:0] RDATA, PIN_IN, PIN_OUT, PIN_OE, DMA_ADDR, DMA_WDATA;
    logic IRQ, DMA_WE;
    logic rd_q = 1'b0; // Read data due this cycle
    logic [4:0] cpin, dpin; // Chosen clock and data pins
    logic [31:0] rq[$], dq_a[$], dq_d[$]; // Expected reads and DMA words
    int num_errors, checks, seed;
    pdmc_core #(.PIN_W(5), .CNT_W(15)) i_pdmc_core (.MCLK(MCLK), .RESET_N(RESET_N),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .DMA_ADDR(DMA_ADDR),
        .DMA_WDATA(DMA_WDATA), .DMA_WE(DMA_WE));
    pdmc_mic_model i_pdmc_mic_model (.clk(MCLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
        .clk_pin(cpin), .din_pin(dpin), .pin_in(PIN_IN));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    // One-cycle read strobe, expectation noted first
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
    endtask
    task automatic exp_dma(input logic [31:0] a, input logic [31:0] d);
        dq_a.push_back(a);
        dq_d.push_back(d);
    endtask
    // Bounded wait until every noted result has shown up
    task automatic drain();
        int n;
        n = 0;
        while ((dq_a.size() != 0 || rq.size() != 0) && n < 30000) begin
            @(posedge MCLK);
            n++;
        end
        if (n >= 30000) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Output watcher: read data one cycle after the strobe, DMA words on the pulse
    always @(posedge MCLK) begin
        rd_q <= RD;
        if (rd_q === 1'b1 && rq.size() != 0) begin
            chk(RDATA, rq.pop_front());
        end
        if (DMA_WE === 1'b1) begin
            if (dq_a.size() == 0) begin
                // A word nobody expected, e.g. a partial word after stop
                checks++;
                num_errors++;
                $display("[FAIL] t=%0t seen=%h exp=none", $time, DMA_WDATA);
            end else begin
                chk(DMA_ADDR, dq_a.pop_front());
                chk(DMA_WDATA, dq_d.pop_front());
            end
        end
    end
    // 25 MHz reference
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // Main sequence
    initial begin
        RESET_N = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 12'h000;
        WDATA = 32'h0000_0000;
        num_errors = 0;
        checks = 0;
        seed = 26113;
        r = $random(seed);
        cpin = {1'b0, r[3:0]};
        dpin = {1'b1, r[7:4]};
        ptr = {16'h0000, r[23:10], 2'b00};
        repeat (5) @(posedge MCLK);
        RESET_N <= 1'b1;
        // Reset values and an unmapped hole
        rd(`PDMC_OFS_ROUTING, 32'h0000_0000);
        rd(`PDMC_OFS_GAIN_LEFT, 32'h0000_0028);
        rd(`PDMC_OFS_GAIN_RIGHT, 32'h0000_0028);
        rd(`PDMC_OFS_CLKDIV, `PDMC_RST_CLKDIV);
        rd(`PDMC_OFS_PSELCLK, `PDMC_RST_PSEL);
        rd(12'h7FC, 32'h0000_0000);
        // Gain codes at and beyond the ends of the range
        wr(`PDMC_OFS_GAIN_LEFT, 32'h0000_007F);
        rd(`PDMC_OFS_GAIN_LEFT, 32'h0000_0050);
        wr(`PDMC_OFS_GAIN_RIGHT, 32'h0000_0000);
        rd(`PDMC_OFS_GAIN_RIGHT, 32'h0000_0000);
        // Stereo, left on fall, +6 dB left and -6 dB right
        wr(`PDMC_OFS_GAIN_LEFT, 32'h0000_0034);
        wr(`PDMC_OFS_GAIN_RIGHT, 32'h0000_001C);
        wr(`PDMC_OFS_PSELCLK, {27'h0, cpin});
        wr(`PDMC_OFS_PSELDIN, {27'h0, dpin});
        wr(`PDMC_OFS_PTR, ptr);
        wr(`PDMC_OFS_MAXCNT, 32'h0000_0004);
        wr(`PDMC_OFS_IRQMASK, 32'h0000_0004);
        wr(`PDMC_OFS_ENABLE, 32'h0000_0001);
        rd(`PDMC_OFS_PTR, ptr);
        chk(PIN_OE, 32'h1 << cpin);
        // Left saturates at +6 dB, right halves to -8192
        exp_dma(ptr, 32'hE000_7FFF);
        exp_dma(ptr + 32'h4, 32'hE000_7FFF);
        exp_dma(ptr, 32'hE000_7FFF);
        wr(`PDMC_OFS_TASK, 32'h0000_0001);
        drain();
        chk({31'h0, IRQ}, 32'h1);
        rd(`PDMC_OFS_STATUS, 32'h0000_0005);
        drain();
        repeat (2) @(posedge MCLK);
        chk({31'h0, IRQ}, 32'h0);
        // Stop with the end event masked: partial decimation window dropped, no interrupt
        wr(`PDMC_OFS_IRQMASK, 32'h0000_0001);
        wr(`PDMC_OFS_TASK, 32'h0000_0002);
        repeat (4) @(posedge MCLK);
        chk({31'h0, IRQ}, 32'h0);
        rd(`PDMC_OFS_STATUS, 32'h0000_0006);
        // Mono, left on rise sees the low-phase zeros, x80 with matching divider
        wr(`PDMC_OFS_ROUTING, 32'h0000_0003);
        wr(`PDMC_OFS_RATIO, 32'h0000_0001);
        wr(`PDMC_OFS_CLKDIV, `PDMC_DIV_1280K);
        wr(`PDMC_OFS_GAIN_LEFT, 32'h0000_001C);
        wr(`PDMC_OFS_PTR, ptr + 32'h40);
        exp_dma(ptr + 32'h40, 32'hD800_D800);
        exp_dma(ptr + 32'h44, 32'hD800_D800);
        wr(`PDMC_OFS_TASK, 32'h0000_0001);
        drain();
        wr(`PDMC_OFS_TASK, 32'h0000_0002);
        // Remaining divider codes: 70 cycles each, two to three mic clock periods, stopped before any word
        for (int i = 0; i < 4; i++) begin
            wr(`PDMC_OFS_CLKDIV, (i == 0) ? `PDMC_DIV_1000K : (i == 1) ? `PDMC_DIV_1067K :
                (i == 2) ? `PDMC_DIV_1231K : `PDMC_DIV_1333K);
            wr(`PDMC_OFS_TASK, 32'h0000_0001);
            repeat (70) @(posedge MCLK);
            wr(`PDMC_OFS_TASK, 32'h0000_0002);
        end
        repeat (10) @(posedge MCLK);
        chk(PIN_OUT, 32'h0000_0000);
        end_sim();
    end
endmodule // tb
